// ===== bench/afecm_mode_ctrl_chk.sv
`timescale 1ns/1ps
module afecm_mode_ctrl_chk #(
  parameter RES_W = 16,
  parameter BYTE_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire avsRead,
  input wire avsWrite,
  input wire avsWaitRequest,
  input wire analogueSupplyOk,
  input wire digitalCoreSupplyOk,
  input wire [RES_W-1:0] adcResult,
  input wire adcValid,
  input wire powerOnResetN,
  input wire [2:0] chanPowerDown,
  input wire convStart,
  input wire [1:0] convChannel,
  input wire [1:0] appliedSet,
  input wire [BYTE_W-1:0] outByte,
  input wire outByteValid,
  input wire outByteHigh
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hi;
    outByteValid && outByteHigh && outByte == $past(adcResult[RES_W-1:BYTE_W]);
  endsequence
  sequence s_lo;
    outByteValid && !outByteHigh && outByte == $past(adcResult[BYTE_W-1:0], 2);
  endsequence
  property p_ack;
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered");
  property p_one;
    !avsWaitRequest |=> avsWaitRequest;
  endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");
  property p_por;
    !(analogueSupplyOk && digitalCoreSupplyOk) |-> ##[1:4] !powerOnResetN;
  endproperty
  a_por: assert property (p_por)
    else $error("supply low without reset");
  property p_hold;
    !powerOnResetN |=> chanPowerDown == 3'h7 && !outByteValid && !convStart;
  endproperty
  a_hold: assert property (p_hold)
    else $error("activity while held in reset");
  property p_byte;
    adcValid && powerOnResetN |=> s_hi ##1 s_lo;
  endproperty
  a_byte: assert property (p_byte)
    else $error("result bytes wrong");
  property p_pwr;
    convStart |-> !chanPowerDown[convChannel];
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("converting a powered down channel");
  property p_line;
    convStart && chanPowerDown == 3'h6 |-> convChannel == 2'h0;
  endproperty
  a_line: assert property (p_line)
    else $error("line mode not on red");
  property p_set;
    convStart && chanPowerDown != 3'h6 |-> appliedSet == convChannel;
  endproperty
  a_set: assert property (p_set)
    else $error("set differs from channel");
endmodule

// ===== bench/afecm_mode_ctrl_test.sv
`timescale 1ns/1ps
`include "afecm_regs.vh"
module afecm_mode_ctrl_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avsAddress = 6'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [3:0] avsByteEnable = 4'h0;
  logic analogueSupplyOk = 1'b0;
  logic digitalCoreSupplyOk = 1'b0;
  wire [31:0] avsReadData;
  wire [15:0] adcResult;
  wire [8:0] gainApplied;
  wire [7:0] offsetApplied, outByte;
  wire [2:0] chanPowerDown;
  wire [1:0] convChannel, appliedSet;
  wire avsWaitRequest, resetSampleStrobe, videoSampleStrobe, adcValid, powerOnResetN;
  wire convStart, compatTimingSelect, clampClose, outByteValid, outByteHigh;
  int badCount = 0;
  int nTests = 0;
  logic [31:0] seed = 32'h0000_91c7;
  logic [31:0] q, w;
  logic [16:0] go[3];
  logic [3:0] qc[$];
  logic [16:0] qg[$];
  logic clampHit = 1'b0;
  logic [3:0] beSel = 4'hf;
  afecm_mode_ctrl u_afecm_mode_ctrl (.clk, .rst_n, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .analogueSupplyOk,
    .digitalCoreSupplyOk, .resetSampleStrobe, .videoSampleStrobe, .adcResult, .adcValid,
    .powerOnResetN, .chanPowerDown, .convStart, .convChannel, .gainApplied, .offsetApplied,
    .appliedSet, .compatTimingSelect, .clampClose, .outByte, .outByteValid, .outByteHigh);
  afecm_scanner_model u_afecm_scanner_model (.clk, .rst_n, .convStart, .convChannel,
    .gainApplied, .offsetApplied, .videoSampleStrobe, .resetSampleStrobe, .adcResult,
    .adcValid);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      qc.push_back({appliedSet, convChannel});
      qg.push_back({gainApplied, offsetApplied});
    end
    if (clampClose === 1'b1) clampHit <= 1'b1;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] pdExp(input logic [1:0] m, input logic [1:0] s);
    if (m == `AFECM_MD_COLOUR) return `AFECM_PD_NONE;
    if (m == `AFECM_MD_TWOCH) return `AFECM_PD_TWOCH;
    if (m == `AFECM_MD_MONO && s == `AFECM_CH_G) return 3'h5;
    if (m == `AFECM_MD_MONO && s == `AFECM_CH_B) return 3'h3;
    return `AFECM_PD_LINE;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsRead <= rd;
    avsWrite <= !rd;
    avsWriteData <= d;
    avsByteEnable <= beSel;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic pix(input logic [1:0] m, input logic [1:0] ch, input logic [1:0] st);
    int n;
    logic [1:0] e;
    n = (m == 0) ? 3 : (m == 1) ? 2 : 1;
    qc.delete();
    qg.delete();
    u_afecm_scanner_model.pulse(1'b0);
    repeat (20) @(posedge clk);
    chk(qc.size(), n, "slot count");
    foreach (qc[i]) begin
      e = (m < 2) ? i[1:0] : st;
      chk(qc[i], {e, (m < 2) ? i[1:0] : (m == 2) ? ch : 2'h0}, "set/chan");
      chk(qg[i], go[e], "gain/offset");
    end
    chk(chanPowerDown, pdExp(m, ch), "power down");
  endtask
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, `AFECM_OFFR_OFF, 32'h0000_0012);
    chk(powerOnResetN, 0, "por held");
    analogueSupplyOk <= 1'b1;
    repeat (3) @(posedge clk);
    digitalCoreSupplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1, `AFECM_STATUS_OFF, 0);
    chk(q[0], 1, "por released");
    bus(1, `AFECM_OFFR_OFF, 0);
    chk(q, `AFECM_OFF_RST, "write dropped");
    $display("power on test done");
    bus(0, `AFECM_SWRST_OFF, 0);
    bus(1, 6'h3c, 0);
    chk(q, 0, "unmapped");
    for (int i = 0; i < 3; i++) begin
      go[i] = 17'(rnd());
      bus(0, 6'(`AFECM_OFFR_OFF + 4 * i), go[i][7:0]);
      bus(0, 6'(`AFECM_GAINR_OFF + 4 * i), go[i][16:8]);
      bus(1, 6'(`AFECM_OFFR_OFF + 4 * i), 0);
      chk(q, go[i][7:0], "offset");
      bus(1, 6'(`AFECM_GAINR_OFF + 4 * i), 0);
      chk(q, go[i][16:8], "gain");
    end
    beSel = 4'h2;
    bus(0, `AFECM_GAINR_OFF, 32'h0000_0000);
    beSel = 4'hf;
    go[0][16] = 1'b0;
    bus(1, `AFECM_GAINR_OFF, 0);
    chk(q, go[0][16:8], "byte lanes");
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        w = (rnd() & 32'h0000_0080) | (s << 5) | (s << 2) | m;
        bus(0, `AFECM_MODE_OFF, w);
        pix(2'(m), 2'(s % 3), 2'(s % 3));
        chk(compatTimingSelect, w[7], "compat");
      end
    end
    $display("mode test done");
    bus(0, `AFECM_MODE_OFF, 32'h0000_0013);
    for (int k = 0; k < 5; k++) begin
      pix(2'h3, 2'h0, 2'(k % 3));
      u_afecm_scanner_model.pulse(1'b1);
    end
    bus(0, `AFECM_MODE_OFF, 32'h0000_0000);
    bus(0, `AFECM_MODE_OFF, 32'h0000_0013);
    pix(2'h3, 2'h0, 2'h0);
    $display("auto cycle test done");
    bus(0, `AFECM_MODE_OFF, 32'h0000_0093);
    clampHit = 1'b0;
    u_afecm_scanner_model.pulse(1'b1);
    repeat (6) @(posedge clk);
    chk(clampHit, 0, "clamp off");
    bus(0, `AFECM_MODE_OFF, 32'h0000_0193);
    clampHit = 1'b0;
    u_afecm_scanner_model.pulse(1'b0);
    repeat (6) @(posedge clk);
    chk(clampHit, 1, "clamp on");
    $display("clamp test done");
    analogueSupplyOk <= 1'b0;
    repeat (6) @(posedge clk);
    chk(powerOnResetN, 0, "supply low");
    analogueSupplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1, `AFECM_MODE_OFF, 0);
    chk(q, `AFECM_MODE_RST, "defaults");
    $display("supply drop test done");
    conclude();
  end
endmodule
bind afecm_mode_ctrl afecm_mode_ctrl_chk #(.RES_W(RES_W), .BYTE_W(BYTE_W)) u_afecm_mode_ctrl_chk (
  .clk, .rst_n, .avsRead, .avsWrite, .avsWaitRequest, .analogueSupplyOk,
  .digitalCoreSupplyOk, .adcResult, .adcValid, .powerOnResetN, .chanPowerDown,
  .convStart, .convChannel, .appliedSet, .outByte, .outByteValid, .outByteHigh);

// ===== bench/afecm_scanner_model.sv
`timescale 1ns/1ps
module afecm_scanner_model (
  input wire clk,
  input wire rst_n,
  input wire convStart,
  input wire [1:0] convChannel,
  input wire [8:0] gainApplied,
  input wire [7:0] offsetApplied,
  output logic videoSampleStrobe,
  output logic resetSampleStrobe,
  output logic [15:0] adcResult,
  output logic adcValid
);
  logic [15:0] pend[$];
  logic [1:0] gap;
  initial begin
    videoSampleStrobe = 1'b0;
    resetSampleStrobe = 1'b0;
    adcValid = 1'b0;
    adcResult = 16'h0000;
  end
  task automatic pulse(input logic rs);
    @(posedge clk);
    if (rs) resetSampleStrobe <= 1'b1;
    else videoSampleStrobe <= 1'b1;
    repeat (4) @(posedge clk);
    resetSampleStrobe <= 1'b0;
    videoSampleStrobe <= 1'b0;
  endtask
  // Converter answers one result every third cycle, bus toggles when idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adcValid <= 1'b0;
      gap <= 2'h0;
      pend.delete();
    end else begin
      if (convStart) pend.push_back({convChannel, gainApplied[5:0], offsetApplied});
      adcValid <= 1'b0;
      adcResult <= ~adcResult;
      if (gap != 2'h0) gap <= gap - 2'h1;
      else if (pend.size() > 0) begin
        adcResult <= pend.pop_front();
        adcValid <= 1'b1;
        gap <= 2'h2;
      end
    end
  end
endmodule

// ===== hdl/afecm_mode_ctrl.v
// Summary of operation
// - While power-on reset is low, logic stays reset and control writes are dropped.
// - On power-on reset release, registers hold defaults and writes are accepted.
// - Power-on reset asserts when analogue or digital supply monitor reports low.
// - Colour mode samples three inputs and converts all three per pixel.
// - Two-channel mode converts red and green per pixel, blue powered down.
// - Mono mode uses selected channel only, others down; selection changeable between lines.
// - Line-by-line mode routes red input through red channel, green and blue down.
// - Auto-cycle: each reset-sample pulse steps gain/offset set red-green-blue-red.
// - Line-by-line mode also allows register-selected gain/offset set.
// - Each channel has an 8-bit offset and 9-bit gain register.
// - Each 16-bit result leaves over an 8-bit bus as two bytes.
// - Compatibility bit switches to older sampling timing, same control interface.
// - All configuration registers, offsets and gains included, are writable.
// - Auto-cycling in compatibility timing uses reset-sample strobe for cycling only.
`timescale 1ns/1ps
`include "afecm_regs.vh"
module afecm_mode_ctrl #(
  parameter RES_W = 16,
  parameter BYTE_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [5:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  input wire analogueSupplyOk,
  input wire digitalCoreSupplyOk,
  input wire resetSampleStrobe,
  input wire videoSampleStrobe,
  input wire [RES_W-1:0] adcResult,
  input wire adcValid,
  output reg powerOnResetN,
  output reg [2:0] chanPowerDown,
  output reg convStart,
  output reg [1:0] convChannel,
  output reg [`AFECM_GAIN_W-1:0] gainApplied,
  output reg [`AFECM_OFF_W-1:0] offsetApplied,
  output reg [1:0] appliedSet,
  output reg compatTimingSelect,
  output reg clampClose,
  output reg [BYTE_W-1:0] outByte,
  output reg outByteValid,
  output reg outByteHigh
);
  reg anaS1_q, anaS2_q, digS1_q, digS2_q;
  reg rsmpS1_q, rsmpS2_q, rsmpD_q;
  reg vsmpS1_q, vsmpS2_q, vsmpD_q;
  reg [`AFECM_MODE_W-1:0] mode_q;
  reg [`AFECM_OFF_W-1:0] offR_q, offG_q, offB_q;
  reg [`AFECM_GAIN_W-1:0] gainR_q, gainG_q, gainB_q;
  reg [1:0] cyclePtr_q;
  reg [1:0] slotIdx_q;
  reg slotBusy_q;
  reg [BYTE_W-1:0] lowByte_q;
  reg lowPend_q;
  reg [31:0] rdData_d;
  reg [1:0] setSel_d;
  reg [1:0] chan_d;

  wire [1:0] procMode = mode_q[`AFECM_MODE_MSB:`AFECM_MODE_LSB];
  wire [1:0] monoSel = mode_q[`AFECM_MSEL_MSB:`AFECM_MSEL_LSB];
  wire [1:0] manualSet = mode_q[`AFECM_SSEL_MSB:`AFECM_SSEL_LSB];
  wire autoCycle = mode_q[`AFECM_ACYC_BIT];
  wire compat = mode_q[`AFECM_COMPAT_BIT];
  wire clampCtl = mode_q[`AFECM_CLCTL_BIT];
  wire lineMode = (procMode == `AFECM_MD_LINE);
  wire rsmpRise = rsmpS2_q & ~rsmpD_q;
  wire vsmpFall = ~vsmpS2_q & vsmpD_q;
  wire vsmpRise = vsmpS2_q & ~vsmpD_q;
  // Older timing starts a pixel on the video strobe rising edge
  wire pixelStart = compat ? vsmpRise : vsmpFall;
  wire busReq = (avsRead | avsWrite) & avsWaitRequest;
  wire wrTake = avsWrite & ~avsWaitRequest & powerOnResetN;
  wire swReset = wrTake && (avsAddress[5:2] == `AFECM_SWRST_OFF >> 2);
  wire lineEnter = wrTake && (avsAddress[5:2] == `AFECM_MODE_OFF >> 2)
    && !lineMode && (avsWriteData[`AFECM_MODE_MSB:`AFECM_MODE_LSB] == `AFECM_MD_LINE);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function wordHit;
    input [5:0] addr;
    input [5:0] off;
    begin
      wordHit = (addr[5:2] == off[5:2]);
    end
  endfunction

  // Number of converter slots per pixel
  function [1:0] slotCount;
    input [1:0] md;
    begin
      if (md == `AFECM_MD_COLOUR) begin
        slotCount = 2'h3;
      end else if (md == `AFECM_MD_TWOCH) begin
        slotCount = 2'h2;
      end else begin
        slotCount = 2'h1;
      end
    end
  endfunction

  function [1:0] monoChan;
    input [1:0] sel;
    begin
      monoChan = (sel == `AFECM_CH_G || sel == `AFECM_CH_B) ? sel : `AFECM_CH_R;
    end
  endfunction

  // Two-flop synchronisers for pins and supply monitors
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      anaS1_q <= 1'b0;
      anaS2_q <= 1'b0;
      digS1_q <= 1'b0;
      digS2_q <= 1'b0;
      rsmpS1_q <= 1'b0;
      rsmpS2_q <= 1'b0;
      rsmpD_q <= 1'b0;
      vsmpS1_q <= 1'b0;
      vsmpS2_q <= 1'b0;
      vsmpD_q <= 1'b0;
      powerOnResetN <= 1'b0;
    end else begin
      anaS1_q <= analogueSupplyOk;
      anaS2_q <= anaS1_q;
      digS1_q <= digitalCoreSupplyOk;
      digS2_q <= digS1_q;
      rsmpS1_q <= resetSampleStrobe;
      rsmpS2_q <= rsmpS1_q;
      rsmpD_q <= rsmpS2_q;
      vsmpS1_q <= videoSampleStrobe;
      vsmpS2_q <= vsmpS1_q;
      vsmpD_q <= vsmpS2_q;
      powerOnResetN <= anaS2_q & digS2_q;
    end
  end

  // Bus slave: one wait cycle, then a single-cycle acknowledge
  always @* begin
    rdData_d = 32'h0000_0000;
    if (wordHit(avsAddress, `AFECM_MODE_OFF)) begin
      rdData_d[`AFECM_MODE_W-1:0] = mode_q;
    end else if (wordHit(avsAddress, `AFECM_STATUS_OFF)) begin
      rdData_d = {25'h000_0000, chanPowerDown, cyclePtr_q, slotBusy_q, powerOnResetN};
    end else if (wordHit(avsAddress, `AFECM_OFFR_OFF)) begin
      rdData_d[`AFECM_OFF_W-1:0] = offR_q;
    end else if (wordHit(avsAddress, `AFECM_OFFG_OFF)) begin
      rdData_d[`AFECM_OFF_W-1:0] = offG_q;
    end else if (wordHit(avsAddress, `AFECM_OFFB_OFF)) begin
      rdData_d[`AFECM_OFF_W-1:0] = offB_q;
    end else if (wordHit(avsAddress, `AFECM_GAINR_OFF)) begin
      rdData_d[`AFECM_GAIN_W-1:0] = gainR_q;
    end else if (wordHit(avsAddress, `AFECM_GAING_OFF)) begin
      rdData_d[`AFECM_GAIN_W-1:0] = gainG_q;
    end else if (wordHit(avsAddress, `AFECM_GAINB_OFF)) begin
      rdData_d[`AFECM_GAIN_W-1:0] = gainB_q;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end else begin
      avsWaitRequest <= ~busReq;
      if (busReq && avsRead) begin
        avsReadData <= rdData_d;
      end
    end
  end

  wire [31:0] wrMerged = merge(rdData_d, avsWriteData, avsByteEnable);

  // Control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `AFECM_MODE_RST;
      offR_q <= `AFECM_OFF_RST;
      offG_q <= `AFECM_OFF_RST;
      offB_q <= `AFECM_OFF_RST;
      gainR_q <= `AFECM_GAIN_RST;
      gainG_q <= `AFECM_GAIN_RST;
      gainB_q <= `AFECM_GAIN_RST;
    end else if (!powerOnResetN || swReset) begin
      mode_q <= `AFECM_MODE_RST;
      offR_q <= `AFECM_OFF_RST;
      offG_q <= `AFECM_OFF_RST;
      offB_q <= `AFECM_OFF_RST;
      gainR_q <= `AFECM_GAIN_RST;
      gainG_q <= `AFECM_GAIN_RST;
      gainB_q <= `AFECM_GAIN_RST;
    end else if (wrTake) begin
      if (wordHit(avsAddress, `AFECM_MODE_OFF)) begin
        mode_q <= wrMerged[`AFECM_MODE_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_OFFR_OFF)) begin
        offR_q <= wrMerged[`AFECM_OFF_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_OFFG_OFF)) begin
        offG_q <= wrMerged[`AFECM_OFF_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_OFFB_OFF)) begin
        offB_q <= wrMerged[`AFECM_OFF_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_GAINR_OFF)) begin
        gainR_q <= wrMerged[`AFECM_GAIN_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_GAING_OFF)) begin
        gainG_q <= wrMerged[`AFECM_GAIN_W-1:0];
      end else if (wordHit(avsAddress, `AFECM_GAINB_OFF)) begin
        gainB_q <= wrMerged[`AFECM_GAIN_W-1:0];
      end
    end
  end

  // Auto-cycle pointer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyclePtr_q <= `AFECM_CH_R;
    end else if (!powerOnResetN || swReset || lineEnter) begin
      cyclePtr_q <= `AFECM_CH_R;
    end else if (lineMode && autoCycle && rsmpRise) begin
      if (cyclePtr_q == `AFECM_CH_B) begin
        cyclePtr_q <= `AFECM_CH_R;
      end else begin
        cyclePtr_q <= cyclePtr_q + 2'h1;
      end
    end
  end

  // Sample channel and register set of the current slot
  always @* begin
    chan_d = slotIdx_q;
    setSel_d = slotIdx_q;
    if (procMode == `AFECM_MD_MONO) begin
      chan_d = monoChan(monoSel);
      setSel_d = monoChan(monoSel);
    end else if (lineMode) begin
      chan_d = `AFECM_CH_R;
      setSel_d = autoCycle ? cyclePtr_q : monoChan(manualSet);
    end
  end

  // Converter slot sequencer, one slot per clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slotBusy_q <= 1'b0;
      slotIdx_q <= 2'h0;
      convStart <= 1'b0;
      convChannel <= `AFECM_CH_R;
      appliedSet <= `AFECM_CH_R;
      gainApplied <= `AFECM_GAIN_RST;
      offsetApplied <= `AFECM_OFF_RST;
    end else if (!powerOnResetN) begin
      slotBusy_q <= 1'b0;
      slotIdx_q <= 2'h0;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      if (pixelStart) begin
        slotBusy_q <= 1'b1;
        slotIdx_q <= 2'h0;
      end else if (slotBusy_q) begin
        convStart <= 1'b1;
        convChannel <= chan_d;
        appliedSet <= setSel_d;
        gainApplied <= (setSel_d == `AFECM_CH_G) ? gainG_q :
          (setSel_d == `AFECM_CH_B) ? gainB_q : gainR_q;
        offsetApplied <= (setSel_d == `AFECM_CH_G) ? offG_q :
          (setSel_d == `AFECM_CH_B) ? offB_q : offR_q;
        if (slotIdx_q + 2'h1 >= slotCount(procMode)) begin
          slotBusy_q <= 1'b0;
          slotIdx_q <= 2'h0;
        end else begin
          slotIdx_q <= slotIdx_q + 2'h1;
        end
      end
    end
  end

  // Channel power-down and clamp control
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chanPowerDown <= `AFECM_PD_ALL;
      compatTimingSelect <= 1'b0;
      clampClose <= 1'b0;
    end else if (!powerOnResetN) begin
      chanPowerDown <= `AFECM_PD_ALL;
      compatTimingSelect <= 1'b0;
      clampClose <= 1'b0;
    end else begin
      compatTimingSelect <= compat;
      if (procMode == `AFECM_MD_COLOUR) begin
        chanPowerDown <= `AFECM_PD_NONE;
      end else if (procMode == `AFECM_MD_TWOCH) begin
        chanPowerDown <= `AFECM_PD_TWOCH;
      end else if (procMode == `AFECM_MD_MONO) begin
        chanPowerDown <= `AFECM_PD_ALL & ~(3'h1 << monoChan(monoSel));
      end else begin
        chanPowerDown <= `AFECM_PD_LINE;
      end
      if (compat && lineMode && autoCycle) begin
        clampClose <= clampCtl & vsmpS2_q;
      end else if (compat) begin
        clampClose <= rsmpS2_q & vsmpS2_q;
      end else if (clampCtl) begin
        clampClose <= rsmpS2_q & vsmpS2_q;
      end else begin
        clampClose <= rsmpS2_q;
      end
    end
  end

  // Result serialiser: high byte first, low byte next cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outByte <= {BYTE_W{1'b0}};
      outByteValid <= 1'b0;
      outByteHigh <= 1'b0;
      lowByte_q <= {BYTE_W{1'b0}};
      lowPend_q <= 1'b0;
    end else if (!powerOnResetN) begin
      outByteValid <= 1'b0;
      outByteHigh <= 1'b0;
      lowPend_q <= 1'b0;
    end else if (adcValid) begin
      outByte <= adcResult[RES_W-1 -: BYTE_W];
      outByteValid <= 1'b1;
      outByteHigh <= 1'b1;
      lowByte_q <= adcResult[BYTE_W-1:0];
      lowPend_q <= 1'b1;
    end else if (lowPend_q) begin
      outByte <= lowByte_q;
      outByteValid <= 1'b1;
      outByteHigh <= 1'b0;
      lowPend_q <= 1'b0;
    end else begin
      outByteValid <= 1'b0;
      outByteHigh <= 1'b0;
    end
  end
endmodule

// ===== hdl/afecm_regs.vh
`ifndef AFECM_REGS_VH
`define AFECM_REGS_VH
// Register byte offsets
`define AFECM_SWRST_OFF 6'h00
`define AFECM_MODE_OFF 6'h04
`define AFECM_STATUS_OFF 6'h08
`define AFECM_OFFR_OFF 6'h0C
`define AFECM_OFFG_OFF 6'h10
`define AFECM_OFFB_OFF 6'h14
`define AFECM_GAINR_OFF 6'h18
`define AFECM_GAING_OFF 6'h1C
`define AFECM_GAINB_OFF 6'h20
// Mode register fields
`define AFECM_MODE_LSB 0
`define AFECM_MODE_MSB 1
`define AFECM_MSEL_LSB 2
`define AFECM_MSEL_MSB 3
`define AFECM_ACYC_BIT 4
`define AFECM_SSEL_LSB 5
`define AFECM_SSEL_MSB 6
`define AFECM_COMPAT_BIT 7
`define AFECM_CLCTL_BIT 8
`define AFECM_MODE_W 9
// Processing modes
`define AFECM_MD_COLOUR 2'h0
`define AFECM_MD_TWOCH 2'h1
`define AFECM_MD_MONO 2'h2
`define AFECM_MD_LINE 2'h3
// Channel / register set codes
`define AFECM_CH_R 2'h0
`define AFECM_CH_G 2'h1
`define AFECM_CH_B 2'h2
// Power-down patterns, bit0 red, bit1 green, bit2 blue
`define AFECM_PD_NONE 3'h0
`define AFECM_PD_TWOCH 3'h4
`define AFECM_PD_LINE 3'h6
`define AFECM_PD_ALL 3'h7
// Reset values and register widths
`define AFECM_MODE_RST 9'h000
`define AFECM_OFF_RST 8'h80
`define AFECM_GAIN_RST 9'h000
`define AFECM_OFF_W 8
`define AFECM_GAIN_W 9
`endif
